// ### dma_channel_request_control.sv
// four channel dma controller: request selection, fetch and store engines, ahb-lite registers
// assumes a single 250 MHz clock, synchronous request lines and an external sram arbiter
// Operation
// - moves words between peripherals and sram
// - sram address spans whole data space
// - sram access waits for arbiter grant
// - four independent channels, own configuration
// - per channel direction toward or from peripheral
// - any of 256 peripheral request lines selectable
// - force bit set by one, zero ignored
// - force clears on completion or disable
// - codes 1A/19 pick output compare four/three
// - last channel status, 1111 after reset
//
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "dma_regs.svh"
module dma_channel_request_control
    import dma_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [255:0] request_lines,
    output logic sram_req,
    output logic sram_we,
    output logic [15:0] sram_addr,
    output logic [15:0] sram_wdata,
    input wire logic sram_gnt,
    input wire logic [15:0] sram_rdata,
    output logic periph_req,
    output logic periph_we,
    output logic [15:0] periph_addr,
    output logic [15:0] periph_wdata,
    input wire logic periph_ack,
    input wire logic [15:0] periph_rdata
);
    localparam int ITEM_W = $bits(xfer_item_t);

    // bus slave state
    logic wr_pend_q, rd_pend_q, hreadyout_q, accept;
    logic [7:0] acc_addr_q;
    logic [31:0] hrdata_q, rd_value;
    // channel state
    logic [7:0] select_q [NUM_CHANNELS];
    logic [15:0] chan_sram_addr_q [NUM_CHANNELS], chan_periph_addr_q [NUM_CHANNELS];
    logic [NUM_CHANNELS-1:0] enable_q, dir_q, force_q, issued_q, pend_q, want, force_done;
    logic [3:0] last_channel_q;
    // engine state
    fetch_state_t fetch_state_q;
    store_state_t store_state_q;
    xfer_item_t fetch_item_q, store_item_q, pop_item;
    logic [1:0] pick_ch;
    logic any_want, fetch_bus_nx, fetch_go, store_go, sram_done, periph_done, fetch_done, store_done;
    logic sram_req_q, sram_we_q, periph_req_q, periph_we_q;
    logic [15:0] sram_addr_q, sram_wdata_q, periph_addr_q, periph_wdata_q;

    stream_if #(.WIDTH(ITEM_W)) push_s (), pop_s ();

    // address phase taken only when the bus is ready and the transfer is real
    assign accept = hsel & hready & htrans[1];

    // ahb-lite slave: writes take no wait, reads take one wait state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            acc_addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
        end else begin
            wr_pend_q <= accept & hwrite;
            acc_addr_q <= accept ? haddr[7:0] : acc_addr_q;
            if (accept && !hwrite) begin
                rd_pend_q <= 1'b1;
                hreadyout_q <= 1'b0;
            end else if (rd_pend_q) begin
                rd_pend_q <= 1'b0;
                hrdata_q <= rd_value;
                hreadyout_q <= 1'b1;
            end
        end
    end

    // register read multiplexer, unmapped words read as zero
    always_comb begin
        rd_value = 32'h0000_0000;
        if (acc_addr_q[7:6] == `REG_REGION_CHANNELS) begin
            case (acc_addr_q[3:0])
                `REG_OFS_REQ_SELECT: begin
                    rd_value[`REQ_SELECT_FORCE_BIT] = force_q[acc_addr_q[5:4]];
                    rd_value[`REQ_SELECT_SOURCE_MSB:0] = select_q[acc_addr_q[5:4]];
                end
                `REG_OFS_CONTROL: begin
                    rd_value[`CONTROL_ENABLE_BIT] = enable_q[acc_addr_q[5:4]];
                    rd_value[`CONTROL_DIR_BIT] = dir_q[acc_addr_q[5:4]];
                end
                `REG_OFS_SRAM_ADDR: rd_value[15:0] = chan_sram_addr_q[acc_addr_q[5:4]];
                `REG_OFS_PERIPH_ADDR: rd_value[15:0] = chan_periph_addr_q[acc_addr_q[5:4]];
                default: rd_value = 32'h0000_0000;
            endcase
        end else if (acc_addr_q == `REG_ADDR_LAST_CHANNEL) begin
            rd_value[3:0] = last_channel_q;
        end
    end

    // per channel registers, request capture and force handling
    generate
        for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_chan
            logic wr_this, wr_ctrl, wr_sel, go_this;
            assign wr_this = wr_pend_q && (acc_addr_q[7:6] == `REG_REGION_CHANNELS) && (acc_addr_q[5:4] == 2'(i));
            assign wr_ctrl = wr_this && (acc_addr_q[3:0] == `REG_OFS_CONTROL);
            assign wr_sel = wr_this && (acc_addr_q[3:0] == `REG_OFS_REQ_SELECT);
            assign go_this = fetch_go && (pick_ch == 2'(i));
            // a channel wants service on a pending request, or once per force
            assign want[i] = enable_q[i] & (force_q[i] ? !issued_q[i] : pend_q[i]);
            assign force_done[i] = store_done & store_item_q.forced & (store_item_q.chan == 2'(i));

            // configuration written by software
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    enable_q[i] <= 1'b0;
                    dir_q[i] <= 1'b0;
                    select_q[i] <= `SELECT_RESET;
                    chan_periph_addr_q[i] <= `ADDR_RESET;
                end else begin
                    if (wr_ctrl) begin
                        enable_q[i] <= hwdata[`CONTROL_ENABLE_BIT];
                        dir_q[i] <= hwdata[`CONTROL_DIR_BIT];
                    end
                    if (wr_sel) begin
                        select_q[i] <= hwdata[`REQ_SELECT_SOURCE_MSB:0];
                    end
                    if (wr_this && (acc_addr_q[3:0] == `REG_OFS_PERIPH_ADDR)) begin
                        chan_periph_addr_q[i] <= hwdata[15:0];
                    end
                end
            end

            // sram pointer, written by software, stepped per fetched word
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    chan_sram_addr_q[i] <= `ADDR_RESET;
                end else if (wr_this && (acc_addr_q[3:0] == `REG_OFS_SRAM_ADDR)) begin
                    chan_sram_addr_q[i] <= hwdata[15:0];
                end else if (go_this) begin
                    chan_sram_addr_q[i] <= chan_sram_addr_q[i] + `SRAM_ADDR_STEP;
                end
            end

            // force bit: only a one sets it, and a set beats a hardware clear
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    force_q[i] <= 1'b0;
                    issued_q[i] <= 1'b0;
                end else begin
                    if (wr_sel && hwdata[`REQ_SELECT_FORCE_BIT]) begin
                        force_q[i] <= 1'b1;
                    end else if (force_done[i] || !enable_q[i]) begin
                        force_q[i] <= 1'b0;
                    end
                    if (go_this && force_q[i]) begin
                        issued_q[i] <= 1'b1;
                    end else if (!force_q[i] || force_done[i]) begin
                        issued_q[i] <= 1'b0; // a force rewritten as the last one ends is served again
                    end
                end
            end

            // selected request line latched as pending, new request beats the take
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    pend_q[i] <= 1'b0;
                end else if (enable_q[i] && !force_q[i] && request_lines[select_q[i]]) begin
                    pend_q[i] <= 1'b1;
                end else if (go_this || !enable_q[i] || force_q[i]) begin
                    pend_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // fixed priority pick, channel 0 highest
    always_comb begin
        pick_ch = 2'd0;
        any_want = 1'b0;
        for (int k = NUM_CHANNELS - 1; k >= 0; k--) begin
            if (want[k]) begin
                pick_ch = 2'(k);
                any_want = 1'b1;
            end
        end
    end

    // engine launch; bus 1 is the peripheral side, 0 is sram; store side has priority
    assign pop_item = xfer_item_t'(pop_s.data);
    assign fetch_bus_nx = !dir_q[pick_ch];
    assign store_go = (store_state_q == STORE_IDLE) && pop_s.valid
        && !((fetch_state_q == FETCH_WAIT) && (!fetch_item_q.dir == pop_item.dir));
    assign fetch_go = (fetch_state_q == FETCH_IDLE) && any_want && push_s.ready
        && !((store_state_q == STORE_WAIT) && (store_item_q.dir == fetch_bus_nx))
        && !(store_go && (pop_item.dir == fetch_bus_nx));
    assign pop_s.ready = store_go;
    assign sram_done = sram_req_q & sram_gnt;
    assign periph_done = periph_req_q & periph_ack;
    assign fetch_done = (fetch_state_q == FETCH_WAIT) && (fetch_item_q.dir ? sram_done : periph_done);
    assign store_done = (store_state_q == STORE_WAIT) && (store_item_q.dir ? periph_done : sram_done);

    // fetched word enters the staging fifo
    always_comb begin
        push_s.valid = fetch_done;
        push_s.data = fetch_item_q;
        push_s.data[15:0] = fetch_item_q.dir ? sram_rdata : periph_rdata;
    end

    dma_word_fifo #(.WIDTH(ITEM_W), .DEPTH(`STAGING_FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_s(push_s.sink),
        .out_s(pop_s.source)
    );

    // fetch engine: reads one source word per taken request
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fetch_state_q <= FETCH_IDLE;
            fetch_item_q <= '0;
        end else begin
            case (fetch_state_q)
                FETCH_IDLE: begin
                    if (fetch_go) begin
                        fetch_state_q <= FETCH_WAIT;
                        fetch_item_q.chan <= pick_ch;
                        fetch_item_q.dir <= dir_q[pick_ch];
                        fetch_item_q.forced <= force_q[pick_ch];
                        fetch_item_q.sram_addr <= chan_sram_addr_q[pick_ch];
                        fetch_item_q.periph_addr <= chan_periph_addr_q[pick_ch];
                    end
                end
                FETCH_WAIT: fetch_state_q <= fetch_done ? FETCH_IDLE : FETCH_WAIT;
                default: fetch_state_q <= FETCH_IDLE;
            endcase
        end
    end

    // store engine: writes one staged word to its destination
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            store_state_q <= STORE_IDLE;
            store_item_q <= '0;
        end else begin
            case (store_state_q)
                STORE_IDLE: begin
                    if (store_go) begin
                        store_state_q <= STORE_WAIT;
                        store_item_q <= pop_item;
                    end
                end
                STORE_WAIT: store_state_q <= store_done ? STORE_IDLE : STORE_WAIT;
                default: store_state_q <= STORE_IDLE;
            endcase
        end
    end

    // sram port, request held until the arbiter grants it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sram_req_q <= 1'b0;
            sram_we_q <= 1'b0;
            sram_addr_q <= `ADDR_RESET;
            sram_wdata_q <= 16'h0000;
        end else if (fetch_go && !fetch_bus_nx) begin
            sram_req_q <= 1'b1;
            sram_we_q <= 1'b0;
            sram_addr_q <= chan_sram_addr_q[pick_ch];
        end else if (store_go && !pop_item.dir) begin
            sram_req_q <= 1'b1;
            sram_we_q <= 1'b1;
            sram_addr_q <= pop_item.sram_addr;
            sram_wdata_q <= pop_item.data;
        end else if (sram_done) begin
            sram_req_q <= 1'b0;
        end
    end

    // peripheral port, request held until acknowledged
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            periph_req_q <= 1'b0;
            periph_we_q <= 1'b0;
            periph_addr_q <= `ADDR_RESET;
            periph_wdata_q <= 16'h0000;
        end else if (fetch_go && fetch_bus_nx) begin
            periph_req_q <= 1'b1;
            periph_we_q <= 1'b0;
            periph_addr_q <= chan_periph_addr_q[pick_ch];
        end else if (store_go && pop_item.dir) begin
            periph_req_q <= 1'b1;
            periph_we_q <= 1'b1;
            periph_addr_q <= pop_item.periph_addr;
            periph_wdata_q <= pop_item.data;
        end else if (periph_done) begin
            periph_req_q <= 1'b0;
        end
    end

    // last channel to finish a transfer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            last_channel_q <= `LAST_CHANNEL_RESET;
        end else if (store_done) begin
            last_channel_q <= {2'b00, store_item_q.chan};
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign sram_req = sram_req_q;
    assign sram_we = sram_we_q;
    assign sram_addr = sram_addr_q;
    assign sram_wdata = sram_wdata_q;
    assign periph_req = periph_req_q;
    assign periph_we = periph_we_q;
    assign periph_addr = periph_addr_q;
    assign periph_wdata = periph_wdata_q;
endmodule

// ### dma_regs.svh
// register offsets, field positions, reset values and fixed counts of the dma channel block
// assumes inclusion by bare name from the package and the design modules
`ifndef DMA_REGS_SVH
`define DMA_REGS_SVH

// byte offsets inside a channel window, channel number in address bits 5:4
`define REG_OFS_REQ_SELECT 4'h0
`define REG_OFS_CONTROL 4'h4
`define REG_OFS_SRAM_ADDR 4'h8
`define REG_OFS_PERIPH_ADDR 4'hC
// channel windows live in the region with address bits 7:6 at zero
`define REG_REGION_CHANNELS 2'b00
// last active channel status word
`define REG_ADDR_LAST_CHANNEL 8'h40

// request select register fields
`define REQ_SELECT_FORCE_BIT 15
`define REQ_SELECT_SOURCE_MSB 7
// control register fields
`define CONTROL_ENABLE_BIT 0
`define CONTROL_DIR_BIT 1

// reset values
`define LAST_CHANNEL_RESET 4'hF
`define SELECT_RESET 8'h00
`define ADDR_RESET 16'h0000

// sram address step per transferred word
`define SRAM_ADDR_STEP 16'h0002

// request source codes of note
`define SRC_OUTPUT_COMPARE_UNIT_FOUR 8'h1A
`define SRC_OUTPUT_COMPARE_UNIT_THREE 8'h19
`define SRC_TIMER_THREE 8'h08
`define SRC_TIMER_TWO 8'h07

// staging fifo depth in words
`define STAGING_FIFO_DEPTH 16

`endif

// ### dma_pkg.sv
// types shared by the dma channel block and its staging fifo
// assumes dma_regs.svh is reachable on the include path
package dma_pkg;
    `include "dma_regs.svh"

    localparam int NUM_CHANNELS = 4;

    // fetch engine states, one-hot
    typedef enum logic [1:0] {
        FETCH_IDLE = 2'b01,
        FETCH_WAIT = 2'b10
    } fetch_state_t;

    // store engine states, one-hot
    typedef enum logic [1:0] {
        STORE_IDLE = 2'b01,
        STORE_WAIT = 2'b10
    } store_state_t;

    // one staged word with everything the store side needs
    typedef struct packed {
        logic [1:0] chan;
        logic dir;
        logic forced;
        logic [15:0] sram_addr;
        logic [15:0] periph_addr;
        logic [15:0] data;
    } xfer_item_t;
endpackage

// ### stream_if.sv
// valid/ready word stream between the dma engines and the staging fifo
// assumes both ends share one clock
`timescale 1ns/1ps
interface stream_if #(
    parameter int WIDTH = 8
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

// ### dma_word_fifo.sv
// staging fifo with registered output word
// assumes a power of two depth and one clock domain
`timescale 1ns/1ps
module dma_word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic rst_n,
    stream_if.sink in_s,
    stream_if.source out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] mem_cnt_q;
    logic out_valid_q;
    logic [WIDTH-1:0] out_data_q;
    logic [AW:0] level;
    logic push;
    logic pop;
    logic load;
    logic from_mem;
    logic bypass;
    logic to_mem;

    // handshakes and where a pushed word goes
    assign level = mem_cnt_q + {{AW{1'b0}}, out_valid_q};
    assign in_s.ready = level < (AW + 1)'(DEPTH);
    assign push = in_s.valid & in_s.ready;
    assign pop = out_valid_q & out_s.ready;
    assign load = !out_valid_q | pop;
    assign from_mem = load & (mem_cnt_q != '0);
    assign bypass = load & (mem_cnt_q == '0) & push;
    assign to_mem = push & !bypass;
    assign out_s.valid = out_valid_q;
    assign out_s.data = out_data_q;

    // storage array, no reset needed on data
    always_ff @(posedge clock) begin
        if (to_mem) begin
            mem_q[wr_ptr_q] <= in_s.data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            mem_cnt_q <= '0;
        end else begin
            if (to_mem) begin
                wr_ptr_q <= wr_ptr_q + AW'(1);
            end
            if (from_mem) begin
                rd_ptr_q <= rd_ptr_q + AW'(1);
            end
            mem_cnt_q <= mem_cnt_q + (AW + 1)'(to_mem) - (AW + 1)'(from_mem);
        end
    end

    // head word register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_valid_q <= 1'b0;
            out_data_q <= '0;
        end else if (from_mem) begin
            out_valid_q <= 1'b1;
            out_data_q <= mem_q[rd_ptr_q];
        end else if (bypass) begin
            out_valid_q <= 1'b1;
            out_data_q <= in_s.data;
        end else if (pop) begin
            out_valid_q <= 1'b0;
        end
    end
endmodule

// ### dma_far_side_model.sv
// sram arbiter and peripheral bus seen from the dma block
// assumes one clock; stall sets how long each request waits
`timescale 1ns/1ps
module dma_far_side_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] stall,
    input wire logic sram_req,
    input wire logic [15:0] sram_addr,
    output logic sram_gnt,
    output logic [15:0] sram_rdata,
    input wire logic periph_req,
    input wire logic [15:0] periph_addr,
    output logic periph_ack,
    output logic [15:0] periph_rdata
);
    logic [7:0] s_cnt_q;
    logic [7:0] p_cnt_q;
    // answer once the request has waited the chosen stall
    assign sram_gnt = sram_req && s_cnt_q >= stall;
    assign periph_ack = periph_req && p_cnt_q >= stall;
    // data valid only in the answering cycle, inverted otherwise
    assign sram_rdata = sram_gnt ? sram_addr + 16'h1111 : ~(sram_addr + 16'h1111);
    assign periph_rdata = periph_ack ? periph_addr ^ 16'h5A5A : ~(periph_addr ^ 16'h5A5A);
    // wait counters, cleared after each answer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_cnt_q <= 8'h00;
            p_cnt_q <= 8'h00;
        end else begin
            s_cnt_q <= (sram_req && !sram_gnt) ? s_cnt_q + 8'h01 : 8'h00;
            p_cnt_q <= (periph_req && !periph_ack) ? p_cnt_q + 8'h01 : 8'h00;
        end
    end
endmodule

// ### dma_channel_request_control_properties.sv
// port assertions for the dma channel block
// assumes binding onto the top module, one clock domain
`timescale 1ns/1ps
module dma_channel_request_control_properties (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic sram_req,
    input wire logic sram_we,
    input wire logic [15:0] sram_addr,
    input wire logic [15:0] sram_wdata,
    input wire logic sram_gnt,
    input wire logic periph_req,
    input wire logic periph_we,
    input wire logic [15:0] periph_addr,
    input wire logic periph_ack,
    input wire logic [15:0] periph_rdata
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic ahb_go;
    logic [15:0] fetched_q;
    assign ahb_go = hsel && hready && htrans[1];
    // last word fetched from a peripheral
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fetched_q <= 16'h0000;
        end else if (periph_req && periph_ack && !periph_we) begin
            fetched_q <= periph_rdata;
        end
    end
    chk_read_wait: assert property (ahb_go && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_write_ready: assert property (ahb_go && hwrite |=> hreadyout)
        else $error("write stalled");
    chk_sram_hold: assert property (sram_req && !sram_gnt |=> sram_req && $stable({sram_we, sram_addr, sram_wdata}))
        else $error("sram request changed while stalled");
    chk_periph_hold: assert property (periph_req && !periph_ack |=> periph_req && $stable({periph_we, periph_addr}))
        else $error("peripheral request changed while waiting");
    chk_sram_drop: assert property (sram_req && sram_gnt |=> !sram_req)
        else $error("sram request held after grant");
    chk_periph_drop: assert property (periph_req && periph_ack |=> !periph_req)
        else $error("peripheral request held after ack");
    chk_fetch_store: assert property (periph_req && periph_ack && !periph_we |-> ##[1:300] (sram_req && sram_gnt && sram_we))
        else $error("fetched word never stored");
    chk_store_data: assert property (sram_req && sram_gnt && sram_we |-> sram_wdata == fetched_q)
        else $error("stored word differs from fetched word");
    chk_sram_to_periph: assert property (sram_req && sram_gnt && !sram_we |-> ##[1:300] (periph_req && periph_ack && periph_we))
        else $error("sram word never delivered");
    cover property (sram_req && !sram_gnt ##1 sram_gnt);
    cover property (periph_req && periph_ack && periph_we);
    cover property (ahb_go && !hwrite);
endmodule
bind dma_channel_request_control dma_channel_request_control_properties i_chk (.clock, .rst_n, .hsel, .htrans,
    .hwrite, .hready, .hreadyout, .sram_req, .sram_we, .sram_addr, .sram_wdata, .sram_gnt, .periph_req,
    .periph_we, .periph_addr, .periph_ack, .periph_rdata);

// ### dma_channel_request_control_test.sv
// self-checking bench for the dma channel block
// assumes the far side model answers both buses
`timescale 1ns/1ps
module dma_channel_request_control_test;
    logic clock, rst_n, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [255:0] request_lines;
    logic sram_req, sram_we, sram_gnt, periph_req, periph_we, periph_ack;
    logic [15:0] sram_addr, sram_wdata, sram_rdata, periph_addr, periph_wdata, periph_rdata;
    logic [7:0] stall;
    logic [15:0] wr_addr, wr_data;
    int err_count, tests_run, wr_count, c;
    dma_channel_request_control i_dut (.*, .hsize(3'b010), .hready(hreadyout));
    dma_far_side_model i_far (.*);
    // log every completed write on either bus
    always @(posedge clock) begin
        if (sram_req && sram_gnt && sram_we) begin
            wr_count++;
            {wr_addr, wr_data} = {sram_addr, sram_wdata};
        end
        if (periph_req && periph_ack && periph_we) begin
            wr_count++;
            {wr_addr, wr_data} = {periph_addr, periph_wdata};
        end
    end
    task test_done;
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, seen, exp);
        end
    endtask
    task wait_rdy;
        int n;
        n = 0;
        @(posedge clock);
        while (hreadyout !== 1'b1 && n < 20) begin
            n++;
            @(posedge clock);
        end
        if (n >= 20) begin
            err_count++;
            $display("CHECK FAILED t=%0t bus hang", $time);
            test_done;
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        wait_rdy;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy;
        q = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(q, e);
    endtask
    task setup(input logic [7:0] b, input logic [7:0] src, input logic [15:0] sa, input logic [15:0] pa,
        input logic [31:0] ctl);
        wr(b + 8'h08, {16'h0000, sa});
        wr(b + 8'h0C, {16'h0000, pa});
        wr(b, {24'h00_0000, src});
        wr(b + 8'h04, ctl);
    endtask
    task wait_wr(input int c0, input bit want);
        int n;
        for (n = 0; n < 300 && wr_count == c0; n++) begin
            @(posedge clock);
        end
        if (want && wr_count == c0) begin
            err_count++;
            $display("CHECK FAILED t=%0t no transfer", $time);
            test_done;
        end
    endtask
    task fire(input logic [7:0] src, input bit want);
        c = wr_count;
        request_lines[src] <= 1'b1;
        @(posedge clock);
        request_lines <= '0;
        wait_wr(c, want);
    endtask
    task t_regs;
        rd_chk(8'h40, 32'h0000_000F);
        rd_chk(8'h24, 32'h0000_0000);
        rd_chk(8'h80, 32'h0000_0000);
        wr(8'h10, 32'hFFFF_FF19);
        rd_chk(8'h10, 32'h0000_0019);
        $display("test regs done");
    endtask
    task t_compare;
        setup(8'h20, 8'h1A, 16'h1230, 16'h0050, 32'h0000_0001);
        fire(8'h19, 0);
        check(wr_count, c);
        fire(8'h1A, 1);
        check({wr_addr, wr_data}, 32'h1230_5A0A);
        rd_chk(8'h40, 32'h0000_0002);
        rd_chk(8'h28, 32'h0000_1232);
        $display("test compare done");
    endtask
    task t_timer;
        setup(8'h30, 8'h08, 16'h0400, 16'h0077, 32'h0000_0003);
        fire(8'h07, 0);
        check(wr_count, c);
        fire(8'h08, 1);
        check({wr_addr, wr_data}, 32'h0077_1511);
        wr(8'h30, 32'h0000_0007);
        fire(8'h07, 1);
        check({wr_addr, wr_data}, 32'h0077_1513);
        rd_chk(8'h40, 32'h0000_0003);
        $display("test timer done");
    endtask
    task t_force;
        stall <= 8'd12;
        setup(8'h00, 8'h01, 16'h2000, 16'h0010, 32'h0000_0001);
        c = wr_count;
        wr(8'h00, 32'h0000_8001);
        rd_chk(8'h00, 32'h0000_8001);
        wr(8'h00, 32'h0000_0001);
        rd_chk(8'h00, 32'h0000_8001);
        wait_wr(c, 1);
        check({wr_addr, wr_data}, 32'h2000_5A4A);
        rd_chk(8'h00, 32'h0000_0001);
        rd_chk(8'h40, 32'h0000_0000);
        c = wr_count;
        wr(8'h04, 32'h0000_0000);
        wr(8'h00, 32'h0000_8001);
        rd_chk(8'h00, 32'h0000_0001);
        wait_wr(c, 0);
        check(wr_count, c);
        stall <= 8'd0;
        $display("test force done");
    endtask
    // free running clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // reset, then each scenario in turn
    initial begin
        {rst_n, hwrite, htrans, haddr, hwdata, request_lines, stall} = '0;
        hsel = 1'b1;
        {err_count, tests_run, wr_count} = '0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        t_regs;
        t_compare;
        t_timer;
        t_force;
        test_done;
    end
endmodule
